// [shared/aud_pkg.sv]
// Constants for the audio interface page and buffer register bank.
// Assumes a byte-wide register port with 7-bit offsets, decoded from the serial host port outside this block.
//
// Contract
// R1: Offset 2B page 0 reads length bits 15:8.
// R2: Offset 2C page 0 reads length bits 7:0.
// R3: Length word captured from the incoming burst stream.
// R4: Burst found after sync words F872 then 4E1F.
// R5: Page select decoded at 7F on every page.
// R6: Page bits 1:0 choose page, 00 by default.
// R7: Selected page steers both reads and writes; the code steers reads only and ignores writes other than 7F.
// R8: Page 1 holds channel status, byte n at 2n+channel.
// R9: Byte 0 bit 0 gives consumer/professional mode.
// R10: Professional mode replaces byte 23 with computed CRC.
// R11: Host need not write byte 23 when professional.
// R12: Page bits 7:2 read zero; read-only writes ignored.
package aud_pkg;
  localparam logic [6:0]  ADDR_BURST_LEN_HI = 7'h2B;
  localparam logic [6:0]  ADDR_BURST_LEN_LO = 7'h2C;
  localparam logic [6:0]  ADDR_PAGE_SEL     = 7'h7F;
  localparam logic [6:0]  ADDR_CS_LAST      = 7'h2F;
  localparam logic [1:0]  PAGE_CTRL         = 2'h0;
  localparam logic [1:0]  PAGE_RX           = 2'h1;
  localparam logic [1:0]  PAGE_TX           = 2'h2;
  localparam logic [1:0]  PAGE_RESERVED     = 2'h3;
  localparam logic [1:0]  PAGE_RESET        = 2'h0;
  localparam logic [15:0] BURST_SYNC_WORD_A = 16'hF872;
  localparam logic [15:0] BURST_SYNC_WORD_B = 16'h4E1F;
  localparam logic [15:0] BURST_LEN_RESET   = 16'h0000;
  localparam logic [4:0]  CS_CRC_BYTE       = 5'h17;
  localparam logic [4:0]  CS_MODE_BYTE      = 5'h00;
  localparam int          CS_MODE_BIT       = 0;
  localparam int          CS_DEPTH          = 48;
  localparam logic [7:0]  CRC_POLY          = 8'h1D;
  localparam logic [7:0]  CRC_INIT          = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SYNC_B = 4'b0010,
    ST_TYPE   = 4'b0100,
    ST_LEN    = 4'b1000
  } aud_burst_e;
endpackage

// [rtl/aud_cs_mem.sv]
// Channel-status byte store with one write port and a registered read port.
// Assumes the writer and reader share the single block clock.
`timescale 1ns/10ps
module aud_cs_mem #(
  parameter int DW    = 8,
  parameter int DEPTH = 48,
  parameter int AW    = 6
) (
  // Clock.
  input  wire logic          i_clk,
  // Write port.
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port.
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule // aud_cs_mem

// [rtl/aud_regbank.sv]
// Register bank: burst length status, page select, receiver channel-status buffer, transmitter CRC byte.
// Assumes a byte register port from the serial host front end and a 16-bit word stream from the receiver.
`timescale 1ns/10ps
module aud_regbank
  import aud_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  // Host register port.
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [6:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  output logic      [7:0]  O_RDATA,
  output logic             O_RVALID,
  output logic      [1:0]  O_PAGE,
  // Receiver word stream.
  input  wire logic        I_RX_WORD_VALID,
  input  wire logic [15:0] I_RX_WORD,
  // Receiver channel-status writes.
  input  wire logic        I_RX_CS_WR,
  input  wire logic        I_RX_CS_CHAN,
  input  wire logic [4:0]  I_RX_CS_BYTE,
  input  wire logic [7:0]  I_RX_CS_DATA,
  output logic             O_RX_PROFESSIONAL,
  // Transmitter channel-status byte path.
  input  wire logic        I_TX_CS_VALID,
  input  wire logic        I_TX_CS_CHAN,
  input  wire logic [4:0]  I_TX_CS_BYTE,
  input  wire logic [7:0]  I_TX_CS_DIN,
  output logic             O_TX_CS_VALID,
  output logic      [7:0]  O_TX_CS_DOUT,
  output logic             O_TX_PROFESSIONAL
);
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[7] ^ d[i];
      r  = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : BYTE_ZERO);
    end
    return r;
  endfunction

  aud_burst_e  st_q, st_d;
  logic [15:0] burst_len_q, burst_len_d;
  logic [1:0]  page_q, page_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, src_mem_q, src_mem_d;
  logic        rx_pro_q, rx_pro_d;
  logic [1:0]  tx_pro_q, tx_pro_d;
  logic [1:0][7:0] crc_q, crc_d;
  logic [7:0]  tx_dout_q, tx_dout_d;
  logic        tx_valid_q;
  logic        mem_re;
  logic [7:0]  mem_rdata;
  logic        tx_pro_now;

  // Burst framing: two sync words, then type, then length.
  always_comb begin
    st_d        = st_q;
    burst_len_d = burst_len_q;
    if (I_RX_WORD_VALID) begin
      unique case (st_q)
        ST_IDLE: begin
          if (I_RX_WORD == BURST_SYNC_WORD_A) st_d = ST_SYNC_B; // R4
        end
        ST_SYNC_B: begin
          if (I_RX_WORD == BURST_SYNC_WORD_B) st_d = ST_TYPE; // R4
          else if (I_RX_WORD == BURST_SYNC_WORD_A) st_d = ST_SYNC_B;
          else st_d = ST_IDLE;
        end
        ST_TYPE: begin
          st_d = ST_LEN;
        end
        ST_LEN: begin
          burst_len_d = I_RX_WORD; // R3
          st_d        = ST_IDLE;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q        <= ST_IDLE;
      burst_len_q <= BURST_LEN_RESET;
    end else begin
      st_q        <= st_d;
      burst_len_q <= burst_len_d;
    end
  end

  // Host access decode and read data.
  assign mem_re = I_RD && (page_q == PAGE_RX) && (I_ADDR <= ADDR_CS_LAST); // R7 R8

  always_comb begin
    page_d    = page_q;
    rdata_d   = rdata_q;
    src_mem_d = src_mem_q;
    if (I_WR && (I_ADDR == ADDR_PAGE_SEL)) begin
      page_d = I_WDATA[1:0]; // R5 R6 R12
    end
    if (I_RD) begin
      src_mem_d = mem_re;
      rdata_d   = BYTE_ZERO;
      if (I_ADDR == ADDR_PAGE_SEL) begin
        rdata_d = {6'h00, page_q}; // R5 R12
      end else if (page_q == PAGE_CTRL) begin // R7
        if (I_ADDR == ADDR_BURST_LEN_HI) rdata_d = burst_len_q[15:8]; // R1
        else if (I_ADDR == ADDR_BURST_LEN_LO) rdata_d = burst_len_q[7:0]; // R2
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      page_q    <= PAGE_RESET;
      rdata_q   <= BYTE_ZERO;
      rvalid_q  <= 1'b0;
      src_mem_q <= 1'b0;
    end else begin
      page_q    <= page_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= I_RD;
      src_mem_q <= src_mem_d;
    end
  end

  assign O_RDATA  = src_mem_q ? mem_rdata : rdata_q;
  assign O_RVALID = rvalid_q;
  assign O_PAGE   = page_q;

  // Receiver channel-status buffer, byte n of channel c at 2n+c.
  aud_cs_mem #(
    .DW    (8),
    .DEPTH (CS_DEPTH),
    .AW    (6)
  ) u_rx_cs (
    .i_clk   (I_CLK),
    .i_we    (I_RX_CS_WR),
    .i_waddr ({I_RX_CS_BYTE, I_RX_CS_CHAN}), // R8
    .i_wdata (I_RX_CS_DATA),
    .i_re    (mem_re),
    .i_raddr (I_ADDR[5:0]),
    .o_rdata (mem_rdata)
  );

  // Mode bit of the received stream follows channel 0 byte 0.
  always_comb begin
    rx_pro_d = rx_pro_q;
    if (I_RX_CS_WR && !I_RX_CS_CHAN && (I_RX_CS_BYTE == CS_MODE_BYTE)) begin
      rx_pro_d = I_RX_CS_DATA[CS_MODE_BIT]; // R9
    end
  end

  // Transmitter path: CRC over bytes 0 to 22, inserted as byte 23 when professional.
  assign tx_pro_now = tx_pro_q[I_TX_CS_CHAN];

  always_comb begin
    tx_pro_d  = tx_pro_q;
    crc_d     = crc_q;
    tx_dout_d = tx_dout_q;
    if (I_TX_CS_VALID) begin
      tx_dout_d = I_TX_CS_DIN;
      if (I_TX_CS_BYTE == CS_MODE_BYTE) begin
        tx_pro_d[I_TX_CS_CHAN] = I_TX_CS_DIN[CS_MODE_BIT]; // R9
        crc_d[I_TX_CS_CHAN]    = crc_step(CRC_INIT, I_TX_CS_DIN);
      end else if (I_TX_CS_BYTE < CS_CRC_BYTE) begin
        crc_d[I_TX_CS_CHAN] = crc_step(crc_q[I_TX_CS_CHAN], I_TX_CS_DIN);
      end else if ((I_TX_CS_BYTE == CS_CRC_BYTE) && tx_pro_now) begin
        tx_dout_d = crc_q[I_TX_CS_CHAN]; // R10 R11
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_pro_q   <= 1'b0;
      tx_pro_q   <= 2'b00;
      crc_q      <= {CRC_INIT, CRC_INIT};
      tx_dout_q  <= BYTE_ZERO;
      tx_valid_q <= 1'b0;
    end else begin
      rx_pro_q   <= rx_pro_d;
      tx_pro_q   <= tx_pro_d;
      crc_q      <= crc_d;
      tx_dout_q  <= tx_dout_d;
      tx_valid_q <= I_TX_CS_VALID;
    end
  end

  assign O_RX_PROFESSIONAL = rx_pro_q;
  assign O_TX_PROFESSIONAL = tx_pro_q[0];
  assign O_TX_CS_VALID     = tx_valid_q;
  assign O_TX_CS_DOUT      = tx_dout_q;

  // Checks.
  sequence s_sync_pair;
    I_RX_WORD_VALID && (I_RX_WORD == BURST_SYNC_WORD_A) && ((st_q == ST_IDLE) || (st_q == ST_SYNC_B))
      ##1 I_RX_WORD_VALID && (I_RX_WORD == BURST_SYNC_WORD_B);
  endsequence

  property p_sync_found;
    @(posedge I_CLK) disable iff (!I_RSTN) s_sync_pair |=> (st_q == ST_TYPE);
  endproperty
  a_sync_found: assert property (p_sync_found) else $error("Sync pair did not reach type state."); // R4

  property p_len_capture;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (st_q == ST_LEN) && I_RX_WORD_VALID |=> (burst_len_q == $past(I_RX_WORD)) && (st_q == ST_IDLE);
  endproperty
  a_len_capture: assert property (p_len_capture) else $error("Length word not captured."); // R3

  property p_len_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !((st_q == ST_LEN) && I_RX_WORD_VALID) |=> $stable(burst_len_q);
  endproperty
  a_len_hold: assert property (p_len_hold) else $error("Length changed outside length word."); // R3

  property p_len_hi_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_RD && (page_q == PAGE_CTRL) && (I_ADDR == ADDR_BURST_LEN_HI) |=> O_RVALID && (O_RDATA == $past(burst_len_q[15:8]));
  endproperty
  a_len_hi_read: assert property (p_len_hi_read) else $error("High length byte read wrong."); // R1

  property p_len_lo_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_RD && (page_q == PAGE_CTRL) && (I_ADDR == ADDR_BURST_LEN_LO) |=> (O_RDATA == $past(burst_len_q[7:0]));
  endproperty
  a_len_lo_read: assert property (p_len_lo_read) else $error("Low length byte read wrong."); // R2

  property p_page_write;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_WR && (I_ADDR == ADDR_PAGE_SEL) |=> (page_q == $past(I_WDATA[1:0]));
  endproperty
  a_page_write: assert property (p_page_write) else $error("Page select write lost."); // R5

  property p_page_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_RD && (I_ADDR == ADDR_PAGE_SEL) |=> (O_RDATA == {6'h00, $past(page_q)});
  endproperty
  a_page_read: assert property (p_page_read) else $error("Page select read wrong."); // R12

  property p_page_other;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !(I_WR && (I_ADDR == ADDR_PAGE_SEL)) |=> $stable(page_q);
  endproperty
  a_page_other: assert property (p_page_other) else $error("Page changed without page write."); // R6

  property p_reserved_page;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_RD && (page_q == PAGE_RESERVED) && (I_ADDR != ADDR_PAGE_SEL) |=> (O_RDATA == BYTE_ZERO);
  endproperty
  a_reserved_page: assert property (p_reserved_page) else $error("Reserved page read not zero."); // R7

  property p_rx_mode;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_RX_CS_WR && !I_RX_CS_CHAN && (I_RX_CS_BYTE == CS_MODE_BYTE)
        |=> (O_RX_PROFESSIONAL == $past(I_RX_CS_DATA[CS_MODE_BIT]));
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("Receive mode bit not tracked."); // R9

  property p_crc_insert;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_TX_CS_VALID && (I_TX_CS_BYTE == CS_CRC_BYTE) && tx_pro_now
        |=> O_TX_CS_VALID && (O_TX_CS_DOUT == $past(crc_q[I_TX_CS_CHAN]));
  endproperty
  a_crc_insert: assert property (p_crc_insert) else $error("CRC byte not inserted."); // R10

  property p_tx_pass;
    @(posedge I_CLK) disable iff (!I_RSTN)
      I_TX_CS_VALID && !((I_TX_CS_BYTE == CS_CRC_BYTE) && tx_pro_now) |=> (O_TX_CS_DOUT == $past(I_TX_CS_DIN));
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("Transmit byte altered."); // R10
endmodule // aud_regbank

// [tb/aud_host_model.sv]
// Host controller model for the byte strobe register port.
// Assumes read data arrives with the valid pulse one cycle after the strobe.
`timescale 1ns/10ps
module aud_host_model (
  // Clock.
  input  wire logic       i_clk,
  // Register port.
  output logic            o_wr,
  output logic            o_rd,
  output logic      [6:0] o_addr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end

  // One access; released qualifiers are inverted so stale values never match.
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
                     output logic ok);
    int n;
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    ok = w;
    q = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        q = i_rdata;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
endmodule // aud_host_model

// [tb/audio_if_page_and_buffer_map_tb.sv]
// Self-checking bench for the register bank.
// Assumes the host model above and the package constants.
`timescale 1ns/10ps
module audio_if_page_and_buffer_map_tb;
  import aud_pkg::*;
  typedef struct packed {logic w; logic [6:0] a; logic [7:0] d;} aud_row_s;
  logic I_CLK, I_RSTN, I_WR, I_RD, O_RVALID, rxv, csw, csc, txv, txc, O_TX_CS_VALID, rxp, txp;
  logic [6:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, csd, txd, O_TX_CS_DOUT, q, crc, din, expd;
  logic [1:0] O_PAGE;
  logic [15:0] rxw;
  logic [4:0] csb, txb;
  logic ok;
  int miscompares, n_compared, i, ch;
  aud_row_s rows [17] = '{'{0, 7'h2B, 8'h12}, '{0, 7'h2C, 8'h34}, '{1, 7'h2B, 8'hFF}, '{0, 7'h2B, 8'h12},
    '{1, 7'h7F, 8'hFD}, '{0, 7'h7F, 8'h01}, '{0, 7'h00, 8'h01}, '{0, 7'h2F, 8'hA5}, '{1, 7'h00, 8'h77},
    '{0, 7'h00, 8'h01}, '{0, 7'h30, 8'h00}, '{1, 7'h7F, 8'h02}, '{0, 7'h2B, 8'h00}, '{1, 7'h7F, 8'h03},
    '{0, 7'h2B, 8'h00}, '{1, 7'h7F, 8'h00}, '{0, 7'h2C, 8'h34}};
  logic [15:0] words [10] = '{16'hF872, 16'hF872, 16'h4E1F, 16'h0001, 16'h1234,
    16'hF872, 16'h0000, 16'h4E1F, 16'h0001, 16'h5555};

  aud_host_model u_host (.i_clk(I_CLK), .o_wr(I_WR), .o_rd(I_RD), .o_addr(I_ADDR), .o_wdata(I_WDATA),
    .i_rdata(O_RDATA), .i_rvalid(O_RVALID));
  aud_regbank u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WR(I_WR), .I_RD(I_RD), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_PAGE(O_PAGE), .I_RX_WORD_VALID(rxv),
    .I_RX_WORD(rxw), .I_RX_CS_WR(csw), .I_RX_CS_CHAN(csc), .I_RX_CS_BYTE(csb), .I_RX_CS_DATA(csd),
    .O_RX_PROFESSIONAL(rxp), .I_TX_CS_VALID(txv), .I_TX_CS_CHAN(txc), .I_TX_CS_BYTE(txb),
    .I_TX_CS_DIN(txd), .O_TX_CS_VALID(O_TX_CS_VALID), .O_TX_CS_DOUT(O_TX_CS_DOUT), .O_TX_PROFESSIONAL(txp));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Words go out back to back; the caller lowers the valid afterwards.
  task automatic word(input logic [15:0] w);
    @(posedge I_CLK);
    rxv <= 1'b1;
    rxw <= w;
  endtask

  task automatic cs(input logic c, input logic [4:0] b, input logic [7:0] d);
    @(posedge I_CLK);
    csw <= 1'b1;
    {csc, csb, csd} <= {c, b, d};
    @(posedge I_CLK);
    csw <= 1'b0;
    csd <= ~d;
  endtask

  // Reference CRC: bit 0 first, top bit feeds back.
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    for (int b = 0; b < 8; b++) c = (c[7] ^ d[b]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction

  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end

  initial begin
    {I_RSTN, rxv, csw, csc, txv, txc} = '0;
    {rxw, csb, csd, txb, txd} = '0;
    repeat (2) @(posedge I_CLK);
    #1;
    chk({O_PAGE, O_RVALID, O_TX_CS_VALID}, 16'h0);
    @(posedge I_CLK);
    I_RSTN <= 1'b1;
    for (i = 0; i < 10; i++) word(words[i]);
    @(posedge I_CLK);
    rxv <= 1'b0;
    rxw <= ~rxw;
    cs(1'b0, 5'h00, 8'h01);
    cs(1'b1, 5'h17, 8'hA5);
    #1;
    chk(rxp, 1'b1);
    for (i = 0; i < $size(rows); i++) begin
      u_host.acc(rows[i].w, rows[i].a, rows[i].d, q, ok);
      if (!ok) chk(ok, 1'b1);
      else if (!rows[i].w) chk(q, rows[i].d);
      if (rows[i].w && (rows[i].a == ADDR_PAGE_SEL)) chk(O_PAGE, rows[i].d[1:0]);
    end
    for (ch = 0; ch < 2; ch++) begin
      crc = CRC_INIT;
      for (i = 0; i < 24; i++) begin
        din = (i == 0) ? {7'h00, ch == 0} : ((i == 23) ? 8'h5A : 8'(i * 7));
        expd = (ch == 0 && i == 23) ? crc : din;
        if (i < 23) crc = crc_step(crc, din);
        @(posedge I_CLK);
        txv <= 1'b1;
        {txc, txb, txd} <= {ch[0], i[4:0], din};
        @(posedge I_CLK);
        txv <= 1'b0;
        txd <= ~din;
        #1;
        chk({O_TX_CS_VALID, O_TX_CS_DOUT}, {1'b1, expd});
      end
    end
    chk(txp, 1'b1);
    cs(1'b1, CS_MODE_BYTE, 8'h01);
    #1;
    chk(rxp, 1'b1);
    cs(1'b0, CS_MODE_BYTE, BYTE_ZERO);
    #1;
    chk(rxp, 1'b0);
    u_host.acc(1'b1, ADDR_PAGE_SEL, 8'h01, q, ok);
    @(posedge I_CLK);
    I_RSTN <= 1'b0;
    @(posedge I_CLK);
    #1;
    chk({O_PAGE, rxp, txp, O_RVALID, O_TX_CS_VALID}, 16'h0);
    @(posedge I_CLK);
    I_RSTN <= 1'b1;
    u_host.acc(1'b0, ADDR_PAGE_SEL, BYTE_ZERO, q, ok);
    chk({ok, q}, {1'b1, BYTE_ZERO});
    u_host.acc(1'b0, ADDR_BURST_LEN_HI, BYTE_ZERO, q, ok);
    chk({ok, q}, {1'b1, BYTE_ZERO});
    results();
  end

  initial begin
    #1ms;
    miscompares++;
    results();
  end
endmodule // audio_if_page_and_buffer_map_tb
